// ==== core/rrc_reset_seq.sv ====
// Reset sequencer with cause flags and APB register access
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rrc_cfg.svh"
module rrc_reset_seq #(
  parameter int POR_CYC  = (`RRC_POR_NS + `RRC_CLK_NS - 1) / `RRC_CLK_NS,
  parameter int MON_CYC  = (`RRC_MON_NS + `RRC_CLK_NS - 1) / `RRC_CLK_NS,
  parameter int PWRTA_CYC = `RRC_POWER_UP_TIMER_MS_A * (`RRC_NS_PER_MS / `RRC_CLK_NS),
  parameter int PWRTB_CYC = `RRC_POWER_UP_TIMER_MS_B * (`RRC_NS_PER_MS / `RRC_CLK_NS),
  parameter int PWRTC_CYC = `RRC_POWER_UP_TIMER_MS_C * (`RRC_NS_PER_MS / `RRC_CLK_NS)
) (
  // Clock and power-on reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`RRC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Configuration bits
  input  wire logic                     fail_safe_clock_monitor,
  input  wire logic [1:0]               power_up_timer,
  input  wire rrc_pkg::rrc_osc_type     osc_group_config,
  input  wire logic [4:0]               primary_osc_select,
  // Asynchronous detectors and oscillator status
  input  wire logic                     brownout_det,
  input  wire logic                     master_clear_pin_n,
  input  wire logic                     watchdog_timeout,
  input  wire logic                     osc_running,
  input  wire logic                     ost_expired,
  input  wire logic                     pll_lock,
  input  wire logic                     sys_clk_toggling,
  // Core events on pclk
  input  wire logic                     q1_phase,
  input  wire logic                     sw_reset_req,
  input  wire logic                     trap_conflict,
  input  wire logic                     illegal_op,
  input  wire logic                     int_wake,
  input  wire logic [`RRC_PC_W-1:0]     int_vector,
  input  wire logic                     cpu_sleep,
  input  wire logic                     cpu_idle,
  input  wire logic [`RRC_PC_W-1:0]     cur_pc,
  // Reset and clock control
  output logic                          system_reset,
  output logic                          clock_hold,
  output logic                          clk_fail_trap,
  output rrc_pkg::rrc_osc_type          clk_src_sel,
  output logic                          pc_load,
  output logic [`RRC_PC_W-1:0]          pc_value
);
  import rrc_pkg::*;

  logic [`RRC_SYNC_W-1:0]  sync1_reg;
  logic [`RRC_SYNC_W-1:0]  sync2_reg;
  logic [`RRC_SYNC_W-1:0]  sync_prev_reg;
  logic                    bor_evt;
  logic                    master_clear_pin_evt;
  logic                    wdt_evt;
  logic                    lock_s;
  logic                    run_s;
  logic                    ost_s;
  logic                    tog_s;
  logic                    restart;
  logic                    full_seq;
  logic                    clk_ok;
  logic                    crystal;
  logic [`RRC_CNT_W-1:0]   power_up_timer_cyc;
  rrc_state_type           st_reg;
  rrc_state_type           st_next;
  logic [`RRC_CNT_W-1:0]   cnt_reg;
  logic [`RRC_FLAGS_W-1:0] flags_reg;
  logic [`RRC_FLAGS_W-1:0] flags_next;
  logic                    cf_reg;
  logic                    full_reg;
  logic                    wdt_wake;
  logic                    reset_control_register_wr;

  // Detector levels cross into pclk before anything looks at them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg     <= `RRC_SYNC_RST;
      sync2_reg     <= `RRC_SYNC_RST;
      sync_prev_reg <= `RRC_SYNC_RST;
    end else begin
      sync1_reg     <= {sys_clk_toggling, pll_lock, ost_expired, osc_running,
                        watchdog_timeout, master_clear_pin_n, brownout_det};
      sync2_reg     <= sync1_reg;
      sync_prev_reg <= sync2_reg;
    end
  end

  // Brown-out is never gated by sleep or idle
  assign bor_evt  = sync2_reg[0] && !sync_prev_reg[0];
  assign master_clear_pin_evt = !sync2_reg[1] && sync_prev_reg[1];
  // Watchdog counts on its own RC clock; only its timeout crosses here
  assign wdt_evt  = sync2_reg[2] && !sync_prev_reg[2];
  assign run_s    = sync2_reg[3];
  assign ost_s    = sync2_reg[4];
  assign lock_s   = sync2_reg[5];
  assign tog_s    = sync2_reg[6];

  assign wdt_wake = wdt_evt && cpu_sleep;
  assign restart  = bor_evt || master_clear_pin_evt || (wdt_evt && !cpu_sleep) ||
                    sw_reset_req || trap_conflict || illegal_op;
  assign full_seq = bor_evt;

  function automatic logic is_crystal(input rrc_osc_type g, input logic [4:0] fpr);
    is_crystal = (g == RRC_OSC_LP) ||
                 ((g == RRC_OSC_EXT || g == RRC_OSC_PLL) && !fpr[`RRC_FPR_NONXTAL]);
  endfunction

  assign crystal = is_crystal(clk_src_sel, primary_osc_select);

  always_comb begin
    case (power_up_timer)
      2'h1:    power_up_timer_cyc = PWRTA_CYC[`RRC_CNT_W-1:0];
      2'h2:    power_up_timer_cyc = PWRTB_CYC[`RRC_CNT_W-1:0];
      2'h3:    power_up_timer_cyc = PWRTC_CYC[`RRC_CNT_W-1:0];
      default: power_up_timer_cyc = '0;
    endcase
  end

  // Clock is usable once the selected source has settled
  always_comb begin
    case (clk_src_sel)
      RRC_OSC_FRC, RRC_OSC_LOW_POWER_RC_OSCILLATOR: clk_ok = 1'b1;
      RRC_OSC_PLL: clk_ok = lock_s;
      RRC_OSC_LP:  clk_ok = run_s && ost_s;
      RRC_OSC_EXT: clk_ok = crystal ? (run_s && ost_s) : tog_s;
      default:     clk_ok = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      RRC_ST_HOLD: st_next = full_reg ? RRC_ST_POR : RRC_ST_REL;
      RRC_ST_POR: begin
        if (cnt_reg == POR_CYC[`RRC_CNT_W-1:0] - 1'b1) begin
          if (power_up_timer_cyc != '0)
            st_next = RRC_ST_POWER_UP_TIMER;
          else if (crystal && fail_safe_clock_monitor)
            st_next = RRC_ST_MON;
          else
            st_next = RRC_ST_CLKW;
        end
      end
      RRC_ST_POWER_UP_TIMER: begin
        if (cnt_reg == power_up_timer_cyc - 1'b1)
          st_next = RRC_ST_CLKW;
      end
      RRC_ST_MON: begin
        if (cnt_reg == MON_CYC[`RRC_CNT_W-1:0] - 1'b1)
          st_next = RRC_ST_CLKW;
      end
      RRC_ST_CLKW: begin
        // Without the monitor a dead clock simply keeps us here
        if (clk_ok || fail_safe_clock_monitor)
          st_next = RRC_ST_REL;
      end
      RRC_ST_REL: begin
        if (q1_phase)
          st_next = RRC_ST_RUN;
      end
      RRC_ST_RUN: st_next = RRC_ST_RUN;
      default:    st_next = RRC_ST_HOLD;
    endcase
    if (restart)
      st_next = RRC_ST_HOLD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= RRC_ST_POR;
      full_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      if (restart)
        full_reg <= full_seq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_reg <= '0;
    else if (st_next != st_reg)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign system_reset = (st_reg != RRC_ST_RUN);
  assign clock_hold   = (st_reg == RRC_ST_CLKW);

  // Clock source and fail trap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src_sel   <= RRC_OSC_FRC;
      clk_fail_trap <= 1'b0;
      cf_reg        <= 1'b0;
    end else begin
      clk_fail_trap <= 1'b0;
      // Clear first, so a failure seen in the same cycle still sets the flag
      if (reset_control_register_wr && paddr == `RRC_OFF_OSCC && !pwdata[`RRC_O_CF])
        cf_reg <= 1'b0;
      if (bor_evt || (st_reg == RRC_ST_POR && full_reg && cnt_reg == '0))
        clk_src_sel <= osc_group_config;
      else if (st_reg == RRC_ST_CLKW && !clk_ok && fail_safe_clock_monitor && !restart) begin
        clk_src_sel   <= RRC_OSC_FRC;
        clk_fail_trap <= 1'b1;
        cf_reg        <= 1'b1;
      end
    end
  end

  // Program counter target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_value <= `RRC_VEC_RESET;
      pc_load  <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      if (restart)
        pc_value <= `RRC_VEC_RESET;
      else if (st_reg == RRC_ST_CLKW && !clk_ok && fail_safe_clock_monitor)
        pc_value <= `RRC_VEC_CLKFAIL;
      else if (st_reg == RRC_ST_REL && q1_phase)
        pc_load <= 1'b1;
      else if (st_reg == RRC_ST_RUN && wdt_wake) begin
        pc_value <= cur_pc + `RRC_PC_STEP;
        pc_load  <= 1'b1;
      end else if (st_reg == RRC_ST_RUN && int_wake && cpu_sleep) begin
        pc_value <= int_vector;
        pc_load  <= 1'b1;
      end
    end
  end

  assign reset_control_register_wr = psel && penable && pwrite;

  // Software write first, then events, so a set in the same cycle wins
  always_comb begin
    flags_next = flags_reg;
    if (reset_control_register_wr && paddr == `RRC_OFF_RESET_CONTROL_REGISTER)
      flags_next = pwdata[`RRC_FLAGS_W-1:0] & `RRC_FLAGS_MASK;
    if (bor_evt) begin
      flags_next[`RRC_B_BOR] = 1'b1;
      flags_next[`RRC_B_POR] = 1'b0;
    end else if (master_clear_pin_evt) begin
      flags_next[`RRC_B_PIN_RESET_FLAG]  = 1'b1;
      flags_next[`RRC_B_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      flags_next[`RRC_B_IDLE]  = cpu_idle;
      flags_next[`RRC_B_SLEEP] = cpu_sleep;
      if (!cpu_sleep && !cpu_idle)
        flags_next[`RRC_B_SWR] = 1'b0;
    end else if (wdt_evt) begin
      flags_next[`RRC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      if (cpu_sleep)
        flags_next[`RRC_B_SLEEP] = 1'b1;
      else begin
        flags_next[`RRC_B_PIN_RESET_FLAG]  = 1'b0;
        flags_next[`RRC_B_SWR]   = 1'b0;
        flags_next[`RRC_B_IDLE]  = 1'b0;
        flags_next[`RRC_B_SLEEP] = 1'b0;
      end
    end else if (sw_reset_req) begin
      flags_next[`RRC_B_SWR]   = 1'b1;
      flags_next[`RRC_B_PIN_RESET_FLAG]  = 1'b0;
      flags_next[`RRC_B_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      flags_next[`RRC_B_IDLE]  = 1'b0;
      flags_next[`RRC_B_SLEEP] = 1'b0;
    end else if (trap_conflict)
      flags_next[`RRC_B_TRAP] = 1'b1;
    else if (illegal_op)
      flags_next[`RRC_B_IOP] = 1'b1;
    else if (int_wake && cpu_sleep && st_reg == RRC_ST_RUN)
      flags_next[`RRC_B_SLEEP] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags_reg <= `RRC_FLAGS_RST;
    else
      flags_reg <= flags_next;
  end

  // APB read data is captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `RRC_OFF_RESET_CONTROL_REGISTER: prdata <= {16'h0000, flags_reg};
        `RRC_OFF_OSCC: begin
          prdata <= '0;
          prdata[`RRC_O_COSC+:3] <= clk_src_sel;
          prdata[`RRC_O_LOCK]    <= lock_s;
          prdata[`RRC_O_CF]      <= cf_reg;
        end
        `RRC_OFF_STAT: prdata <= {5'h00, st_reg, pc_value};
        default:       prdata <= '0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == `RRC_OFF_RESET_CONTROL_REGISTER ||
                   paddr == `RRC_OFF_OSCC || paddr == `RRC_OFF_STAT);

  a_bor_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    bor_evt |=> flags_reg[`RRC_B_BOR] && !flags_reg[`RRC_B_POR])
    else $error("brown-out flags wrong");
  a_por_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == RRC_ST_POR && cnt_reg < POR_CYC - 1 && !restart) |=> st_reg == RRC_ST_POR)
    else $error("power-on delay ended early");
  a_release_q1: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(system_reset) |-> $past(q1_phase) && $past(st_reg == RRC_ST_REL))
    else $error("reset released off first phase");
  a_fail_trap: assert property (@(posedge pclk) disable iff (!presetn)
    clk_fail_trap |-> clk_src_sel == RRC_OSC_FRC && pc_value == `RRC_VEC_CLKFAIL)
    else $error("clock trap without fast RC");
  a_frozen_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == RRC_ST_CLKW && !fail_safe_clock_monitor && !clk_ok && !restart)
    |=> st_reg == RRC_ST_CLKW && system_reset)
    else $error("left reset without clock");
  a_master_clear_pin_run: assert property (@(posedge pclk) disable iff (!presetn)
    (master_clear_pin_evt && !bor_evt && !cpu_sleep && !cpu_idle) |=>
    flags_reg[`RRC_B_PIN_RESET_FLAG] && !flags_reg[`RRC_B_SWR] && !flags_reg[`RRC_B_WATCHDOG_TIMEOUT_FLAG])
    else $error("pin reset flags wrong");
  a_swr_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_reset_req && !bor_evt && !master_clear_pin_evt && !wdt_evt) |=>
    flags_reg[`RRC_B_SWR] && !flags_reg[`RRC_B_PIN_RESET_FLAG] && pc_value == `RRC_VEC_RESET)
    else $error("software reset flags wrong");
  a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (wdt_wake && !bor_evt && !master_clear_pin_evt && st_reg == RRC_ST_RUN) |=>
    pc_load && pc_value == $past(cur_pc) + `RRC_PC_STEP && flags_reg[`RRC_B_SLEEP])
    else $error("watchdog wake wrong");
  a_clock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == RRC_ST_CLKW && clk_src_sel == RRC_OSC_PLL && !lock_s) |-> clock_hold)
    else $error("clock released before lock");
endmodule
`default_nettype wire

// ==== core/rrc_cfg.svh ====
// Constants of the reset release and cause flag block
`ifndef RRC_CFG_SVH
`define RRC_CFG_SVH
`define RRC_ADDR_W 8
`define RRC_OFF_RESET_CONTROL_REGISTER 8'h00
`define RRC_OFF_OSCC 8'h04
`define RRC_OFF_STAT 8'h08
`define RRC_FLAGS_W 16
`define RRC_B_POR 0
`define RRC_B_BOR 1
`define RRC_B_IDLE 2
`define RRC_B_SLEEP 3
`define RRC_B_WATCHDOG_TIMEOUT_FLAG 4
`define RRC_B_SWR 6
`define RRC_B_PIN_RESET_FLAG 7
`define RRC_B_IOP 14
`define RRC_B_TRAP 15
`define RRC_FLAGS_MASK 16'hc0df
`define RRC_FLAGS_RST 16'h0003
`define RRC_O_LOCK 5
`define RRC_O_CF 3
`define RRC_O_COSC 12
`define RRC_PC_W 24
`define RRC_VEC_RESET 24'h000000
`define RRC_VEC_CLKFAIL 24'h000004
`define RRC_PC_STEP 24'h000002
`define RRC_FPR_NONXTAL 4
`define RRC_CLK_NS 50
`define RRC_POR_NS 10000
`define RRC_MON_NS 100000
`define RRC_POWER_UP_TIMER_MS_A 4
`define RRC_POWER_UP_TIMER_MS_B 16
`define RRC_POWER_UP_TIMER_MS_C 64
`define RRC_NS_PER_MS 1000000
`define RRC_CNT_W 21
`define RRC_SYNC_W 7
`define RRC_SYNC_RST 7'h02
`endif

// ==== core/rrc_pkg.sv ====
// Types of the reset release and cause flag block
package rrc_pkg;
  typedef enum logic [2:0] {
    RRC_ST_HOLD = 3'h0,
    RRC_ST_POR  = 3'h1,
    RRC_ST_POWER_UP_TIMER = 3'h3,
    RRC_ST_MON  = 3'h2,
    RRC_ST_CLKW = 3'h6,
    RRC_ST_REL  = 3'h7,
    RRC_ST_RUN  = 3'h5
  } rrc_state_type;
  typedef enum logic [2:0] {
    RRC_OSC_LP   = 3'h0,
    RRC_OSC_FRC  = 3'h1,
    RRC_OSC_LOW_POWER_RC_OSCILLATOR = 3'h2,
    RRC_OSC_EXT  = 3'h3,
    RRC_OSC_PLL  = 3'h7
  } rrc_osc_type;
endpackage

// ==== testbench/rrc_far_side.sv ====
// Far-side model: supply detectors, master clear pin, watchdog and clock
`timescale 1ns/1ps
`default_nettype none
module rrc_far_side (
  // Clock and bench control
  input  wire logic        pclk,
  input  wire logic        system_reset,
  input  wire logic [15:0] late_cyc,
  input  wire logic [2:0]  pulse_req,
  // Detector and oscillator levels
  output logic             brownout_det,
  output logic             master_clear_pin_n,
  output logic             watchdog_timeout,
  output logic             clk_ok
);
  logic [2:0]  kind_reg = 3'h0;
  logic [2:0]  len_reg  = 3'h0;
  logic [15:0] run_reg  = 16'h0;
  // Held several cycles so the synchronisers cannot miss it
  always_ff @(posedge pclk) begin
    if (pulse_req != 3'h0) begin
      kind_reg <= pulse_req;
      len_reg  <= 3'h5;
    end else if (len_reg != 3'h0) begin
      len_reg <= len_reg - 3'h1;
    end else begin
      kind_reg <= 3'h0;
    end
  end
  assign brownout_det       = kind_reg[0];
  assign master_clear_pin_n = ~kind_reg[1];
  assign watchdog_timeout   = kind_reg[2];
  // Oscillator, start-up timer and lock come up late_cyc cycles into a reset
  always_ff @(posedge pclk) begin
    if (!system_reset) begin
      run_reg <= 16'h0;
    end else if (run_reg < late_cyc) begin
      run_reg <= run_reg + 16'h1;
    end
  end
  assign clk_ok = !system_reset || (run_reg >= late_cyc);
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench of the reset sequencer and its cause flags
`timescale 1ns/1ps
`default_nettype none
`include "rrc_cfg.svh"
module testbench;
  import rrc_pkg::*;
  localparam int POR_C = 4;
  localparam int MON_C = 8;
  typedef struct packed {
    logic [2:0]  ev;
    logic        slp;
    logic        idl;
    logic [15:0] set;
    logic [15:0] clr;
    logic [23:0] pc;
  } rrc_row_type;
  // Events: 0 sw, 1 trap, 2 illegal, 3 int wake, 4 brown-out, 5 pin, 6 watchdog
  rrc_row_type rows [12] = '{
    '{3'h0, 1'b0, 1'b0, 16'h0040, 16'h009c, 24'h0},
    '{3'h1, 1'b0, 1'b0, 16'h8000, 16'h0000, 24'h0},
    '{3'h2, 1'b0, 1'b0, 16'h4000, 16'h0000, 24'h0},
    '{3'h3, 1'b1, 1'b0, 16'h0008, 16'h0000, 24'h000123},
    '{3'h4, 1'b0, 1'b0, 16'h0002, 16'h0001, 24'h0},
    '{3'h4, 1'b1, 1'b0, 16'h0002, 16'h0001, 24'h0},
    '{3'h4, 1'b0, 1'b1, 16'h0002, 16'h0001, 24'h0},
    '{3'h5, 1'b0, 1'b0, 16'h0080, 16'h005c, 24'h0},
    '{3'h5, 1'b1, 1'b0, 16'h0088, 16'h0014, 24'h0},
    '{3'h5, 1'b0, 1'b1, 16'h0084, 16'h0018, 24'h0},
    '{3'h6, 1'b0, 1'b0, 16'h0010, 16'h00cc, 24'h0},
    '{3'h6, 1'b1, 1'b0, 16'h0018, 16'h0000, 24'h001002}
  };
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er, q1p, hseen, cfseen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fail_safe_clock_monitor, q1_phase, cpu_sleep, cpu_idle, clk_ok;
  logic [1:0]  power_up_timer, q1_cnt;
  rrc_osc_type osc_group_config, clk_src_sel;
  logic [4:0]  primary_osc_select;
  logic        brownout_det, master_clear_pin_n, watchdog_timeout;
  logic        osc_running, ost_expired, pll_lock, sys_clk_toggling;
  logic        sw_reset_req, trap_conflict, illegal_op, int_wake;
  logic        system_reset, clock_hold, clk_fail_trap, pc_load;
  logic [23:0] int_vector, cur_pc, pc_value;
  logic [15:0] late, pre;
  logic [6:0]  evs;
  int          n_mismatch, n_checks, n, lo;
  assign {osc_running, ost_expired, pll_lock, sys_clk_toggling} = {4{clk_ok}};
  assign {int_wake, illegal_op, trap_conflict, sw_reset_req} = evs[3:0];
  // Long counts shortened so every delay case fits the run
  rrc_reset_seq #(.POR_CYC(POR_C), .MON_CYC(MON_C), .PWRTA_CYC(10), .PWRTB_CYC(20),
    .PWRTC_CYC(30)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fail_safe_clock_monitor, .power_up_timer, .osc_group_config,
    .primary_osc_select, .brownout_det, .master_clear_pin_n, .watchdog_timeout,
    .osc_running, .ost_expired, .pll_lock, .sys_clk_toggling, .q1_phase, .sw_reset_req,
    .trap_conflict, .illegal_op, .int_wake, .int_vector, .cpu_sleep, .cpu_idle, .cur_pc,
    .system_reset, .clock_hold, .clk_fail_trap, .clk_src_sel, .pc_load, .pc_value);
  rrc_far_side i_far (.pclk, .system_reset, .late_cyc(late), .pulse_req(evs[6:4]),
    .brownout_det, .master_clear_pin_n, .watchdog_timeout, .clk_ok);
  initial begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (!presetn) begin
      q1_cnt   <= 2'h0;
      q1_phase <= 1'b0;
    end else begin
      q1_cnt   <= q1_cnt + 2'h1;
      q1_phase <= (q1_cnt == 2'h3);
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic fire(input logic [2:0] ev);
    @(posedge pclk);
    evs <= 7'h01 << ev;
    @(posedge pclk);
    evs <= 7'h00;
  endtask
  task automatic wait_ld(input int lim);
    hseen = 1'b0;
    cfseen = 1'b0;
    for (n = 0; n < lim && pc_load !== 1'b1; n++) begin
      q1p = q1_phase;
      @(posedge pclk);
      hseen |= clock_hold;
      cfseen |= clk_fail_trap;
    end
    chk32({31'h0, pc_load}, 32'h1);
  endtask
  initial begin
    #3000000;
    n_mismatch++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {fail_safe_clock_monitor, power_up_timer, primary_osc_select} = {1'b1, 2'h0, 5'h10};
    osc_group_config = RRC_OSC_EXT;
    {cpu_sleep, cpu_idle, evs, late} = 25'h0;
    int_vector = 24'h000123;
    cur_pc = 24'h001000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge pclk);
    chk32({31'h0, system_reset}, 32'h1);
    presetn <= 1'b1;
    wait_ld(400);
    chk32({8'h0, pc_value}, 32'h0);
    apb(1'b0, `RRC_OFF_RESET_CONTROL_REGISTER, 32'h0, rd, er);
    chk32(rd, 32'h3);
    apb(1'b0, `RRC_OFF_OSCC, 32'h0, rd, er);
    chk32({29'h0, rd[14:12]}, 32'h3);
    for (int p = 0; p < 2; p++) begin
      foreach (rows[i]) begin
        pre = (p == 1) ? 16'hc0df : 16'h0000;
        apb(1'b1, `RRC_OFF_RESET_CONTROL_REGISTER, {32{p[0]}}, rd, er);
        cpu_sleep <= rows[i].slp;
        cpu_idle  <= rows[i].idl;
        fire(rows[i].ev);
        wait_ld(200);
        chk32({8'h0, pc_value}, {8'h0, rows[i].pc});
        if (rows[i].pc == 24'h0) begin
          chk32({31'h0, q1p}, 32'h1);
        end
        chk32({31'h0, system_reset}, 32'h0);
        cpu_sleep <= 1'b0;
        cpu_idle  <= 1'b0;
        apb(1'b0, `RRC_OFF_RESET_CONTROL_REGISTER, 32'h0, rd, er);
        chk32(rd, {16'h0, (pre & ~rows[i].clr) | rows[i].set});
      end
    end
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk32({31'h0, er}, 32'h1);
    // Delays measured from the brown-out; slack covers sync and phase wait
    for (int i = 0; i < 5; i++) begin
      power_up_timer <= (i < 3) ? 2'(i + 1) : 2'h0;
      primary_osc_select <= (i == 4) ? 5'h10 : 5'h00;
      fail_safe_clock_monitor <= (i != 4);
      lo = POR_C + ((i < 3) ? 10 * (i + 1) : (i == 3) ? MON_C : 0);
      fire(3'h4);
      wait_ld(200);
      chk32(32'(n >= lo && n <= lo + 12), 32'h1);
    end
    osc_group_config <= RRC_OSC_PLL;
    fail_safe_clock_monitor <= 1'b0;
    late <= 16'h0028;
    fire(3'h4);
    wait_ld(300);
    chk32({29'h0, clk_src_sel}, 32'h7);
    chk32(32'(hseen && n >= 40), 32'h1);
    apb(1'b0, `RRC_OFF_OSCC, 32'h0, rd, er);
    chk32({31'h0, rd[5]}, 32'h1);
    late <= 16'hffff;
    fire(3'h4);
    repeat (150) @(posedge pclk);
    chk32({30'h0, system_reset, clock_hold}, 32'h3);
    late <= 16'h0000;
    wait_ld(50);
    fail_safe_clock_monitor <= 1'b1;
    late <= 16'hffff;
    fire(3'h4);
    wait_ld(200);
    chk32({4'h0, cfseen, clk_src_sel, pc_value}, {4'h0, 1'b1, 3'h1, 24'h000004});
    apb(1'b0, `RRC_OFF_OSCC, 32'h0, rd, er);
    chk32({31'h0, rd[3]}, 32'h1);
    apb(1'b1, `RRC_OFF_OSCC, 32'h0, rd, er);
    apb(1'b0, `RRC_OFF_OSCC, 32'h0, rd, er);
    chk32({31'h0, rd[3]}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
